// file: hw/timed_io_pkg.sv
`default_nettype none
package timed_io_pkg;

   // ********************************************************************
   // Register map (byte addresses)
   // ********************************************************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_DATA = 8'h04;
   localparam logic [7:0] OFS_COND = 8'h08;
   localparam logic [7:0] OFS_TIME = 8'h0C;
   localparam logic [7:0] OFS_COUNT = 8'h10;
   localparam logic [7:0] OFS_STAMP = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_CB_BASE = 8'h20;

   // ********************************************************************
   // Sizes, reset values and field positions
   // ********************************************************************
   localparam int unsigned NUM_CB = 6;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned XFER_W = 32;
   localparam int unsigned DIV_W = 8;
   localparam int unsigned CTRL_W = 11;
   localparam int unsigned CB_CFG_W = 9;
   localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
   localparam logic [2:0] CB_RESET = 3'h0;
   localparam logic [CB_CFG_W-1:0] CB_CFG_RST = 9'h000;
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
   localparam logic [XFER_W-1:0] WORD_RST = 32'h0000_0000;
   localparam int unsigned ST_FULL_BIT = 0;
   localparam int unsigned ST_VALID_BIT = 1;
   localparam int unsigned ST_BUSY_BIT = 2;

   // ********************************************************************
   // Types
   // ********************************************************************
   typedef enum logic [1:0] {COND_NONE, COND_EQ, COND_NEQ} cond_e;
   typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_RUN} xfer_st_e;

   typedef struct packed {
      logic ready_out_en;
      logic ready_in_en;
      logic timed;
      cond_e cond;
      logic [2:0] clk_sel;
      logic open_drain;
      logic dir_out;
      logic enable;
   } ctrl_s;

   typedef struct packed {
      logic ext_src;
      logic [DIV_W-1:0] div;
   } cb_cfg_s;

endpackage
`default_nettype wire

// file: hw/timed_io_port.sv
`default_nettype none
// Functional notes
// - Port width is 1, 4, 8, 16 or 32
// - All pins of one port share direction
// - Drive pins, or sample with optional condition
// - Each register access finishes without wait states
// - Open-collector: zero drives low, one floats
// - Data passes serdes plus transfer register
// - 16-bit counter schedules transfers, always readable
// - Counter captured as timestamp on transfer
// - Enabled link disables the port's pins
// - Narrower enabled port overrules shared pins
// - Unshared pins stay usable by wider port
// - Transfers always use full port width
// - Six clock blocks, block 0 reference
// - Blocks 1 to 5 programmable rate
// - Block may take 1-bit pin clock
// - Pin clock optionally divided
// - Ready-in accepted, ready-out generated with data
// - Reset attaches port to clock block 0
// - Pin events signalled to scheduler directly
module timed_io_port
   import timed_io_pkg::*;
#(
   parameter int unsigned PORT_W = 32
)
(
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Port pins
   input wire logic [PORT_W-1:0] pin_in,
   output logic [PORT_W-1:0] pin_out,
   output logic [PORT_W-1:0] pin_oe_n,
   // Strobes and external clock pin
   input wire logic ext_clk_pin,
   input wire logic ready_in_strobe,
   output logic ready_out_strobe,
   // Pin sharing from the mux
   input wire logic link_en,
   input wire logic [PORT_W-1:0] narrow_owned,
   // Event scheduler
   output logic event_pulse
);

   localparam int unsigned BEATS = XFER_W / PORT_W;
   localparam logic [5:0] LAST_BEAT = 6'(BEATS - 1);

   // ********************************************************************
   // Input synchronisers
   // ********************************************************************
   logic [PORT_W-1:0] pin_s1_r;
   logic [PORT_W-1:0] pin_s2_r;
   logic rin_s1_r;
   logic rin_s2_r;
   logic ext_s1_r;
   logic ext_s2_r;
   logic ext_s3_r;
   logic ext_edge;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
         rin_s1_r <= 1'b0;
         rin_s2_r <= 1'b0;
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
         ext_s3_r <= 1'b0;
      end
      else
      begin
         pin_s1_r <= pin_in;
         pin_s2_r <= pin_s1_r;
         rin_s1_r <= ready_in_strobe;
         rin_s2_r <= rin_s1_r;
         ext_s1_r <= ext_clk_pin;
         ext_s2_r <= ext_s1_r;
         ext_s3_r <= ext_s2_r;
      end
   end

   assign ext_edge = ext_s2_r & ~ext_s3_r;

   // ********************************************************************
   // APB decode
   // ********************************************************************
   logic setup;
   logic access;
   logic wr_en;
   logic rd_en;
   logic hit_cb;
   logic hit;
   logic [2:0] cb_idx;
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   logic [31:0] rd_mux;

   assign setup = psel & ~penable;
   assign access = psel & penable & pready_r;
   assign wr_en = access & pwrite & ~pslverr_r;
   assign rd_en = access & ~pwrite & ~pslverr_r;
   assign cb_idx = paddr[4:2];
   assign hit_cb = (paddr[7:5] == OFS_CB_BASE[7:5]) && (paddr[1:0] == 2'b00)
      && (cb_idx != 3'h0) && (32'(cb_idx) < NUM_CB);
   assign hit = hit_cb || (paddr == OFS_CTRL) || (paddr == OFS_DATA)
      || (paddr == OFS_COND) || (paddr == OFS_TIME) || (paddr == OFS_COUNT)
      || (paddr == OFS_STAMP) || (paddr == OFS_STATUS);

   // ********************************************************************
   // Clock blocks
   // ********************************************************************
   logic [NUM_CB-1:0] tick;
   logic [CB_CFG_W-1:0] cb_rd [NUM_CB];

   assign tick[0] = 1'b1;
   assign cb_rd[0] = CB_CFG_RST;

   genvar gi;
   generate
      for (gi = 1; gi < NUM_CB; gi++)
      begin : g_cb
         cb_cfg_s cfg_r;
         logic [DIV_W-1:0] div_cnt_r;
         logic src;
         logic cfg_wr;

         assign cfg_wr = wr_en && hit_cb && (cb_idx == 3'(gi));
         assign src = cfg_r.ext_src ? ext_edge : 1'b1;
         assign tick[gi] = src && (div_cnt_r == cfg_r.div);
         assign cb_rd[gi] = cfg_r;

         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               cfg_r <= CB_CFG_RST;
               div_cnt_r <= '0;
            end
            else if (cfg_wr)
            begin
               cfg_r <= cb_cfg_s'(pwdata[CB_CFG_W-1:0]);
               div_cnt_r <= '0;
            end
            else if (src)
            begin
               div_cnt_r <= tick[gi] ? '0 : div_cnt_r + 1'b1;
            end
         end
      end
   endgenerate

   // ********************************************************************
   // Control registers
   // ********************************************************************
   ctrl_s ctrl_r;
   logic [PORT_W-1:0] cond_r;
   logic [CNT_W-1:0] time_r;
   logic tick_sel;

   assign tick_sel = (32'(ctrl_r.clk_sel) < NUM_CB) ? tick[ctrl_r.clk_sel]
      : tick[0];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_r <= ctrl_s'(CTRL_RST);
         cond_r <= '0;
         time_r <= CNT_RST;
      end
      else if (wr_en)
      begin
         if (paddr == OFS_CTRL)
            ctrl_r <= ctrl_s'(pwdata[CTRL_W-1:0]);
         if (paddr == OFS_COND)
            cond_r <= pwdata[PORT_W-1:0];
         if (paddr == OFS_TIME)
            time_r <= pwdata[CNT_W-1:0];
      end
   end

   // ********************************************************************
   // Port counter
   // ********************************************************************
   logic [CNT_W-1:0] cnt_r;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt_r <= CNT_RST;
      else if (ctrl_r.enable && tick_sel)
         cnt_r <= cnt_r + 1'b1;
   end

   // ********************************************************************
   // Transfer engine
   // ********************************************************************
   xfer_st_e st_r;
   xfer_st_e st_nxt;
   logic [XFER_W-1:0] xfer_r;
   logic [XFER_W-1:0] shift_r;
   logic [5:0] beat_r;
   logic xfer_full_r;
   logic rx_valid_r;
   logic [CNT_W-1:0] stamp_r;
   logic time_ok;
   logic cond_ok;
   logic go;
   logic start;
   logic beat;
   logic last;
   logic out_beat;
   logic rx_done;
   logic data_wr;
   logic data_rd;
   logic [XFER_W+PORT_W-1:0] in_wide;
   logic [XFER_W+PORT_W-1:0] out_wide;

   assign data_wr = wr_en && (paddr == OFS_DATA) && ctrl_r.dir_out
      && !xfer_full_r;
   assign data_rd = rd_en && (paddr == OFS_DATA);
   assign time_ok = !ctrl_r.timed || (cnt_r == time_r);
   assign cond_ok = ctrl_r.dir_out || (ctrl_r.cond == COND_NONE)
      || ((ctrl_r.cond == COND_EQ) && (pin_s2_r == cond_r))
      || ((ctrl_r.cond == COND_NEQ) && (pin_s2_r != cond_r));
   assign go = tick_sel && time_ok && cond_ok;
   assign start = (st_r == ST_ARM) && go;
   assign beat = (st_r == ST_RUN) && tick_sel
      && (ctrl_r.dir_out || !ctrl_r.ready_in_en || rin_s2_r);
   assign last = beat && (beat_r == LAST_BEAT);
   assign out_beat = beat && ctrl_r.dir_out;
   assign rx_done = last && !ctrl_r.dir_out;
   assign in_wide = {pin_s2_r, shift_r};
   assign out_wide = {{PORT_W{1'b0}}, shift_r} >> PORT_W;

   always_comb
   begin
      st_nxt = st_r;
      case (st_r)
         ST_IDLE:
            if (ctrl_r.enable && (ctrl_r.dir_out ? xfer_full_r : !rx_valid_r))
               st_nxt = ST_ARM;
         ST_ARM:
            if (start)
               st_nxt = ST_RUN;
         ST_RUN:
            if (last)
               st_nxt = ST_IDLE;
         default:
            st_nxt = ST_IDLE;
      endcase
      if (!ctrl_r.enable)
         st_nxt = ST_IDLE;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r <= ST_IDLE;
         shift_r <= WORD_RST;
         beat_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
         if (start)
         begin
            shift_r <= ctrl_r.dir_out ? xfer_r : WORD_RST;
            beat_r <= '0;
         end
         else if (beat)
         begin
            shift_r <= ctrl_r.dir_out ? out_wide[XFER_W-1:0]
               : in_wide[XFER_W+PORT_W-1:PORT_W];
            beat_r <= beat_r + 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         xfer_r <= WORD_RST;
         xfer_full_r <= 1'b0;
         rx_valid_r <= 1'b0;
         stamp_r <= CNT_RST;
      end
      else
      begin
         if (data_wr)
         begin
            xfer_r <= pwdata;
            xfer_full_r <= 1'b1;
         end
         else if ((start && ctrl_r.dir_out) || !ctrl_r.enable)
            xfer_full_r <= 1'b0;
         if (rx_done)
         begin
            xfer_r <= in_wide[XFER_W+PORT_W-1:PORT_W];
            rx_valid_r <= 1'b1;
         end
         else if (data_rd || !ctrl_r.enable)
            rx_valid_r <= 1'b0;
         if (start)
            stamp_r <= cnt_r;
      end
   end

   // ********************************************************************
   // Pin drivers and strobes
   // ********************************************************************
   logic [PORT_W-1:0] data_r;
   logic [PORT_W-1:0] data_nxt;
   logic [PORT_W-1:0] drive_ok;
   logic [PORT_W-1:0] od_mask;
   logic [PORT_W-1:0] pin_out_r;
   logic [PORT_W-1:0] pin_oe_n_r;
   logic ready_out_r;
   logic event_r;

   assign data_nxt = out_beat ? shift_r[PORT_W-1:0] : data_r;
   assign drive_ok = {PORT_W{ctrl_r.enable && ctrl_r.dir_out && !link_en}}
      & ~narrow_owned;
   assign od_mask = {PORT_W{ctrl_r.open_drain}};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         data_r <= '0;
         pin_out_r <= '0;
         pin_oe_n_r <= '1;
         ready_out_r <= 1'b0;
         event_r <= 1'b0;
      end
      else
      begin
         data_r <= data_nxt;
         pin_out_r <= data_nxt & ~od_mask;
         pin_oe_n_r <= ~(drive_ok & (~od_mask | ~data_nxt));
         if (tick_sel)
            ready_out_r <= out_beat && ctrl_r.ready_out_en;
         event_r <= rx_done
            || (start && !ctrl_r.dir_out && (ctrl_r.cond != COND_NONE));
      end
   end

   // ********************************************************************
   // APB read path
   // ********************************************************************
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      if (hit_cb)
         rd_mux = 32'(cb_rd[cb_idx]);
      else if (paddr == OFS_CTRL)
         rd_mux = 32'(ctrl_r);
      else if (paddr == OFS_DATA)
         rd_mux = xfer_r;
      else if (paddr == OFS_COND)
         rd_mux = 32'(cond_r);
      else if (paddr == OFS_TIME)
         rd_mux = 32'(time_r);
      else if (paddr == OFS_COUNT)
         rd_mux = 32'(cnt_r);
      else if (paddr == OFS_STAMP)
         rd_mux = 32'(stamp_r);
      else if (paddr == OFS_STATUS)
         rd_mux = 32'({st_r != ST_IDLE, rx_valid_r, xfer_full_r});
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end
      else
      begin
         pready_r <= setup;
         pslverr_r <= setup && !hit;
         if (setup && !pwrite)
            prdata_r <= rd_mux;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign pin_out = pin_out_r;
   assign pin_oe_n = pin_oe_n_r;
   assign ready_out_strobe = ready_out_r;
   assign event_pulse = event_r;

   // ********************************************************************
   // Assertions
   // ********************************************************************
   AST_ZERO_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
      setup |=> pready) else $error("access phase not ready at once");
   AST_LINK_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      link_en |=> (pin_oe_n == '1)) else $error("pin driven under link");
   AST_NARROW_WINS: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 ((~pin_oe_n & $past(narrow_owned)) == '0))
      else $error("shared pin driven by wider port");
   AST_OD_LOW: assert property (@(posedge pclk) disable iff (!presetn)
      $past(ctrl_r.open_drain) |-> (pin_out == '0))
      else $error("open collector pin driven high");
   AST_INPUT_FLOAT: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl_r.dir_out |=> (pin_oe_n == '1)) else $error("input port drives");
   AST_CNT_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl_r.enable && tick_sel && cnt_r == CNT_MAX) |=> (cnt_r == CNT_RST))
      else $error("counter did not wrap");
   AST_CNT_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      !tick_sel |=> $stable(cnt_r)) else $error("counter moved without tick");
   AST_STAMP: assert property (@(posedge pclk) disable iff (!presetn)
      start |=> (stamp_r == $past(cnt_r))) else $error("timestamp wrong");
   AST_EVENT: assert property (@(posedge pclk) disable iff (!presetn)
      rx_done |=> event_pulse ##1 !event_pulse)
      else $error("missing event pulse");
   AST_FULL_WORD: assert property (@(posedge pclk) disable iff (!presetn)
      (start && ctrl_r.enable) |=> (beat_r == 6'h00))
      else $error("beat count not reset at start");

endmodule
`default_nettype wire

// file: verif/pin_side_model.sv
`default_nettype none
module pin_side_model
   import timed_io_pkg::*;
(
   // Pins of the port
   input wire logic [31:0] pin_out,
   input wire logic [31:0] pin_oe_n,
   output logic [31:0] pin_in,
   // Strobes and clock
   input wire logic ready_out_strobe,
   output logic ready_in_strobe,
   output logic ext_clk_pin,
   // Commands from the bench
   input wire logic [31:0] drive_val,
   input wire logic drive_en,
   input wire logic rdy_level,
   input wire logic ext_run,
   output logic [31:0] last_word
);
   timeunit 1ns;
   timeprecision 1ps;
   // ******************************************
   // Pin levels, pull-down where nobody drives
   // ******************************************
   always_comb
   begin
      for (int i = 0; i < 32; i++)
      begin
         if (!pin_oe_n[i])
            pin_in[i] = pin_out[i];
         else
            pin_in[i] = drive_en ? drive_val[i] : 1'b0;
      end
   end
   assign ready_in_strobe = rdy_level;
   // ******************************************
   // Word seen when the output strobe rises
   // ******************************************
   initial last_word = 32'h0000_0000;
   always @(posedge ready_out_strobe)
   begin
      #1 last_word = pin_in;
   end
   // ******************************************
   // External clock, still while not running
   // ******************************************
   initial
   begin
      ext_clk_pin = 1'b0;
      forever
      begin
         #100;
         ext_clk_pin = ext_run ? ~ext_clk_pin : 1'b0;
      end
   end
endmodule
`default_nettype wire

// file: verif/timed_io_port_with_clock_blocks_tb.sv
`default_nettype none
module timed_io_port_with_clock_blocks_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import timed_io_pkg::*;
   typedef struct packed
   {
      logic wr;
      logic [7:0] addr;
      logic [31:0] data;
      logic [31:0] exp;
      logic err;
   } row_s;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, pin_in, pin_out, pin_oe_n, narrow_owned;
   logic [31:0] drive_val, last_word, rd, c0, c1;
   logic ext_clk_pin, ready_in_strobe, ready_out_strobe, link_en;
   logic event_pulse, drive_en, rdy_level, ext_run, e;
   int errors, cmp_count, cycles, ev_cnt, ro_cnt;
   row_s rows[11];
   timed_io_port #(.PORT_W(32)) dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .ext_clk_pin(ext_clk_pin), .ready_in_strobe(ready_in_strobe),
      .ready_out_strobe(ready_out_strobe), .link_en(link_en),
      .narrow_owned(narrow_owned), .event_pulse(event_pulse));
   pin_side_model far (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .pin_in(pin_in), .ready_out_strobe(ready_out_strobe),
      .ready_in_strobe(ready_in_strobe), .ext_clk_pin(ext_clk_pin),
      .drive_val(drive_val), .drive_en(drive_en), .rdy_level(rdy_level),
      .ext_run(ext_run), .last_word(last_word));
   // ******************************************
   // Clock, timeout and event count
   // ******************************************
   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      cycles++;
      if (event_pulse === 1'b1)
         ev_cnt++;
      if (ready_out_strobe === 1'b1)
         ro_cnt++;
      if (cycles == 20000)
      begin
         errors++;
         close_out();
      end
   end
   // ******************************************
   // Shared tasks
   // ******************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                      input string msg);
      cmp_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED %0t %s: %h vs %h", $time, msg, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic err);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk(32'(n), 32'h0000_0001, "wait states");
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // ******************************************
   // Main sequence
   // ******************************************
   initial
   begin
      errors = 0;
      cmp_count = 0;
      cycles = 0;
      ev_cnt = 0;
      ro_cnt = 0;
      presetn = 1'b0;
      {psel, penable, pwrite, link_en, drive_en, rdy_level, ext_run} = '0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      narrow_owned = 32'h0000_0000;
      drive_val = 32'h0000_0000;
      rows = '{
         '{1'b0, OFS_CTRL, 32'h0, 32'h0000_0000, 1'b0},
         '{1'b0, OFS_STATUS, 32'h0, 32'h0000_0000, 1'b0},
         '{1'b0, OFS_COUNT, 32'h0, 32'h0000_0000, 1'b0},
         '{1'b0, OFS_STAMP, 32'h0, 32'h0000_0000, 1'b0},
         '{1'b1, OFS_CTRL, 32'h0000_056E, 32'h0, 1'b0},
         '{1'b0, OFS_CTRL, 32'h0, 32'h0000_056E, 1'b0},
         '{1'b1, OFS_TIME, 32'h0000_BEEF, 32'h0, 1'b0},
         '{1'b0, OFS_TIME, 32'h0, 32'h0000_BEEF, 1'b0},
         '{1'b1, 8'h28, 32'h0000_01FF, 32'h0, 1'b0},
         '{1'b0, 8'h28, 32'h0, 32'h0000_01FF, 1'b0},
         '{1'b0, OFS_CB_BASE, 32'h0, 32'h0000_0000, 1'b1}};
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 11; i++)
      begin
         apb(rows[i].wr, rows[i].addr, rows[i].data, rd, e);
         chk(32'(e), 32'(rows[i].err), "error flag");
         if (!rows[i].wr)
            chk(rd, rows[i].exp, "read value");
      end
      $display("test register table done");
      // Output word, counter and stamp
      apb(1'b1, OFS_CTRL, 32'h0000_0403, rd, e);
      ro_cnt = 0;
      apb(1'b1, OFS_DATA, 32'hA5C3_1E79, rd, e);
      wait_cyc(10);
      chk(pin_out, 32'hA5C3_1E79, "pin value");
      chk(pin_oe_n, 32'h0000_0000, "drivers on");
      chk(32'(ro_cnt), 32'h1, "ready out pulses");
      chk(last_word, 32'hA5C3_1E79, "far side word");
      apb(1'b0, OFS_STAMP, 32'h0, rd, e);
      apb(1'b0, OFS_COUNT, 32'h0, c0, e);
      apb(1'b0, OFS_COUNT, 32'h0, c1, e);
      chk(c1 - c0, 32'h0000_0003, "count per pclk");
      chk(32'(rd != 0 && rd < c0), 32'h1, "stamp order");
      $display("test output done");
      // Timed output waits for the counter
      apb(1'b1, OFS_TIME, 32'h0000_0100, rd, e);
      apb(1'b1, OFS_CTRL, 32'h0000_0503, rd, e);
      apb(1'b1, OFS_DATA, 32'h3C96_0FF0, rd, e);
      wait_cyc(10);
      chk(pin_out, 32'hA5C3_1E79, "timed hold");
      wait_cyc(300);
      chk(pin_out, 32'h3C96_0FF0, "timed word");
      chk(last_word, 32'h3C96_0FF0, "far side timed");
      apb(1'b0, OFS_STAMP, 32'h0, rd, e);
      chk(rd, 32'h0000_0100, "stamp at time");
      apb(1'b1, OFS_CTRL, 32'h0000_0403, rd, e);
      $display("test timed done");
      // Narrower port and link take pins
      narrow_owned <= 32'h0000_FFFF;
      apb(1'b1, OFS_DATA, 32'h1234_5678, rd, e);
      wait_cyc(10);
      chk(pin_oe_n, 32'h0000_FFFF, "shared pins");
      chk(pin_out[31:16], 32'h0000_1234, "wide half");
      link_en <= 1'b1;
      wait_cyc(3);
      chk(pin_oe_n, 32'hFFFF_FFFF, "link owns pins");
      link_en <= 1'b0;
      narrow_owned <= 32'h0000_0000;
      $display("test sharing done");
      // Open collector
      apb(1'b1, OFS_CTRL, 32'h0000_0407, rd, e);
      apb(1'b1, OFS_DATA, 32'h0F0F_3355, rd, e);
      wait_cyc(10);
      chk(pin_out, 32'h0000_0000, "oc low only");
      chk(pin_oe_n, 32'h0F0F_3355, "oc release");
      $display("test open collector done");
      // Conditional input gated by ready in
      drive_en <= 1'b1;
      apb(1'b1, OFS_CTRL, 32'h0000_0000, rd, e);
      apb(1'b1, OFS_COND, 32'h0000_1234, rd, e);
      apb(1'b1, OFS_CTRL, 32'h0000_0241, rd, e);
      ev_cnt = 0;
      wait_cyc(10);
      chk(32'(ev_cnt), 32'h0, "no early event");
      drive_val <= 32'h0000_1234;
      wait_cyc(20);
      apb(1'b0, OFS_STATUS, 32'h0, rd, e);
      chk(32'(rd[ST_VALID_BIT]), 32'h0, "held by strobe");
      chk(32'(ev_cnt), 32'h1, "condition event");
      ev_cnt = 0;
      rdy_level <= 1'b1;
      wait_cyc(20);
      chk(32'(ev_cnt), 32'h1, "event seen");
      apb(1'b0, OFS_STATUS, 32'h0, rd, e);
      chk(32'(rd[ST_VALID_BIT]), 32'h1, "rx valid");
      apb(1'b0, OFS_DATA, 32'h0, rd, e);
      chk(rd, 32'h0000_1234, "rx word");
      $display("test input done");
      // External pin clock through block 1, divided by two
      apb(1'b1, OFS_CTRL, 32'h0000_0000, rd, e);
      apb(1'b1, 8'h24, 32'h0000_0101, rd, e);
      apb(1'b1, OFS_CTRL, 32'h0000_0089, rd, e);
      apb(1'b0, OFS_COUNT, 32'h0, c0, e);
      wait_cyc(40);
      apb(1'b0, OFS_COUNT, 32'h0, c1, e);
      chk(c1 - c0, 32'h0000_0000, "still clock");
      ext_run <= 1'b1;
      apb(1'b0, OFS_COUNT, 32'h0, c0, e);
      wait_cyc(40);
      apb(1'b0, OFS_COUNT, 32'h0, c1, e);
      chk(32'((c1 - c0) >= 3 && (c1 - c0) <= 6), 32'h1, "div ticks");
      apb(1'b0, OFS_STATUS, 32'h0, rd, e);
      chk(32'(rd[ST_VALID_BIT]), 32'h0, "neq held");
      drive_val <= 32'h0000_0000;
      wait_cyc(60);
      apb(1'b0, OFS_STATUS, 32'h0, rd, e);
      chk(32'(rd[ST_VALID_BIT]), 32'h1, "neq met");
      ext_run <= 1'b0;
      apb(1'b1, OFS_CTRL, 32'h0000_0403, rd, e);
      apb(1'b1, OFS_DATA, 32'hFFFF_FFFF, rd, e);
      wait_cyc(6);
      chk(pin_oe_n, 32'h0000_0000, "drivers before reset");
      $display("test clock block done");
      // Reset in mid-run
      @(posedge pclk);
      presetn <= 1'b0;
      wait_cyc(2);
      chk(pin_oe_n, 32'hFFFF_FFFF, "reset drivers off");
      presetn <= 1'b1;
      apb(1'b0, OFS_CTRL, 32'h0, rd, e);
      chk(rd, 32'h0000_0000, "reset ctrl");
      $display("test reset done");
      close_out();
   end
endmodule
`default_nettype wire
